// [rtl/power_saving_mode_control.sv]
// How it works
// - reset starts run mode at master clock
// - slow mode divides master clock by 2-16
// - wait during slow mode gives slow-wait
// - wait instruction stops cpu, peripherals keep running
// - wait entry forces mask bits to 10
// - interrupt or reset leaves wait via vector
// - cpu stacks condition codes before servicing
// - halt instruction: timebase enable picks active-halt
// - active-halt exits only on timebase or reset
// - timebase exit no delay; reset exit delayed
// - halt entries force mask; pending irq wakes
// - active-halt keeps only oscillator and timebase
// - active-halt with watchdog gives no reset
// - halt stops oscillator, cpu and peripherals
// - halt wake: oscillator on, delay, then resume
// - watchdog on and option 0: reset not halt
module power_saving_mode_control #(
  parameter int unsigned STAB_SHORT = psm_pkg::STAB_SHORT_CYC,
  parameter int unsigned STAB_LONG  = psm_pkg::STAB_LONG_CYC
) (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               resetn,
  // clock controller configuration
  input  wire logic               slow_mode_enable,
  input  wire logic [1:0]         clock_prescale_select,
  input  wire logic               timebase_irq_enable,
  input  wire logic               long_delay_select,
  // watchdog
  input  wire logic               watchdog_enabled,
  input  wire logic               watchdog_in_stop_option,
  // cpu core and interrupt controller
  input  wire logic               wait_for_irq_instr,
  input  wire logic               halt_instr,
  input  wire logic               irq_pending,
  input  wire logic               irq_wake_capable,
  input  wire logic               timebase_irq,
  input  wire logic               reset_wake_req,
  output logic                    mask_force,
  output logic [1:0]              mask_force_val,
  output logic                    vector_req,
  output logic                    vector_is_reset,
  output logic                    wdg_reset_req,
  // clock gating and status
  output psm_pkg::clk_gate_s      clk_gates,
  output logic [2:0]              psm_mode
);

  psm_pkg::psm_st_s s_r;
  psm_pkg::psm_st_s s_nxt;

  logic [psm_pkg::CNT_W-1:0] dly;
  logic [psm_pkg::DIV_W-1:0] div_mask;
  logic                      tick;
  logic                      tick_nxt;

  function automatic logic [psm_pkg::DIV_W-1:0] slow_mask(input logic       en,
                                                          input logic [1:0] cp);
    logic [psm_pkg::DIV_W-1:0] m;
    m = '0;
    if (en) begin
      m = psm_pkg::DIV_W'((5'h02 << cp) - 5'h01);
    end
    return m;
  endfunction

  function automatic logic [2:0] mode_of(input psm_pkg::psm_state_e st, input logic slow);
    logic [2:0] m;
    case (st)
      psm_pkg::ST_RUN:   m = slow ? psm_pkg::MODE_SLOW : psm_pkg::MODE_RUN;
      psm_pkg::ST_WAIT:  m = slow ? psm_pkg::MODE_SLOW_WAIT : psm_pkg::MODE_WAIT;
      psm_pkg::ST_AHALT: m = psm_pkg::MODE_ACTIVE_HALT;
      psm_pkg::ST_HALT:  m = psm_pkg::MODE_HALT;
      psm_pkg::ST_HREST: m = psm_pkg::MODE_HALT;
      default:           m = psm_pkg::MODE_STABILISE;
    endcase
    return m;
  endfunction

  // static delay choice; a change mid-count only affects the next wake
  assign dly      = long_delay_select ? psm_pkg::CNT_W'(STAB_LONG)
                                      : psm_pkg::CNT_W'(STAB_SHORT);
  // without slow mode every master clock cycle is a core tick
  assign div_mask = slow_mask(slow_mode_enable, clock_prescale_select);
  assign tick     = (s_r.div_cnt & div_mask) == div_mask;
  // from the register side, so the state copy never feeds itself
  assign tick_nxt = (psm_pkg::DIV_W'(s_r.div_cnt + 4'h1) & div_mask) == div_mask;

  always_comb begin
    s_nxt               = s_r;
    s_nxt.div_cnt       = s_r.div_cnt + 4'h1;
    s_nxt.mask_force    = 1'b0;
    s_nxt.vector_req    = 1'b0;
    s_nxt.wdg_reset_req = 1'b0;

    // guard period after a timebase wake from active-halt
    if (s_r.guard_on && tick) begin
      s_nxt.guard_cnt = s_r.guard_cnt - 13'h0001;
      if (s_r.guard_cnt <= 13'h0001) begin
        s_nxt.guard_on = 1'b0;
      end
    end

    case (s_r.state)
      psm_pkg::ST_RUN: begin
        if (s_r.guard_on && !timebase_irq_enable) begin
          s_nxt.state = psm_pkg::ST_HREST;
        end else if (halt_instr) begin
          if (timebase_irq_enable) begin
            // timebase keeps the watchdog from biting here
            s_nxt.mask_force = 1'b1;
            if (irq_pending) begin
              s_nxt.vector_req      = 1'b1;
              s_nxt.vector_is_reset = 1'b0;
            end else begin
              s_nxt.state = psm_pkg::ST_AHALT;
            end
          end else if (watchdog_enabled && !watchdog_in_stop_option) begin
            s_nxt.wdg_reset_req = 1'b1;
          end else begin
            s_nxt.mask_force = 1'b1;
            if (irq_pending) begin
              s_nxt.state      = psm_pkg::ST_STAB;
              s_nxt.stab_cnt   = dly;
              s_nxt.stab_reset = 1'b0;
            end else begin
              s_nxt.state = psm_pkg::ST_HALT;
            end
          end
        end else if (wait_for_irq_instr) begin
          s_nxt.mask_force = 1'b1;
          if (irq_pending) begin
            s_nxt.vector_req      = 1'b1;
            s_nxt.vector_is_reset = 1'b0;
          end else begin
            s_nxt.state = psm_pkg::ST_WAIT;
          end
        end
      end
      psm_pkg::ST_WAIT: begin
        if (reset_wake_req || irq_pending) begin
          // the cpu stacks the condition codes when it takes the vector
          s_nxt.state           = psm_pkg::ST_RUN;
          s_nxt.vector_req      = 1'b1;
          s_nxt.vector_is_reset = reset_wake_req;
        end
      end
      psm_pkg::ST_AHALT: begin
        if (reset_wake_req) begin
          s_nxt.state      = psm_pkg::ST_STAB;
          s_nxt.stab_cnt   = dly;
          s_nxt.stab_reset = 1'b1;
        end else if (timebase_irq) begin
          s_nxt.state           = psm_pkg::ST_RUN;
          s_nxt.vector_req      = 1'b1;
          s_nxt.vector_is_reset = 1'b0;
          s_nxt.guard_on        = 1'b1;
          s_nxt.guard_cnt       = dly;
        end
      end
      psm_pkg::ST_HALT: begin
        if (reset_wake_req || irq_wake_capable) begin
          s_nxt.state      = psm_pkg::ST_STAB;
          s_nxt.stab_cnt   = dly;
          s_nxt.stab_reset = reset_wake_req;
        end
      end
      psm_pkg::ST_STAB: begin
        if (tick) begin
          s_nxt.stab_cnt = s_r.stab_cnt - 13'h0001;
          if (s_r.stab_cnt <= 13'h0001) begin
            s_nxt.state           = psm_pkg::ST_RUN;
            s_nxt.vector_req      = 1'b1;
            s_nxt.vector_is_reset = s_r.stab_reset;
          end
        end
      end
      psm_pkg::ST_HREST: begin
        // held with cpu, peripherals and timebase stopped, oscillator running, until the guard period runs out
        if (!s_r.guard_on || (s_r.guard_cnt <= 13'h0001 && tick)) begin
          s_nxt.state = psm_pkg::ST_RUN;
        end
      end
      default: begin
        s_nxt.state = psm_pkg::ST_RUN;
      end
    endcase

    // outputs follow the next state, so they line up with the state register
    s_nxt.gates.osc      = s_nxt.state != psm_pkg::ST_HALT;
    s_nxt.gates.cpu      = tick_nxt && (s_nxt.state == psm_pkg::ST_RUN);
    s_nxt.gates.periph   = tick_nxt && (s_nxt.state == psm_pkg::ST_RUN ||
                                        s_nxt.state == psm_pkg::ST_WAIT);
    s_nxt.gates.timebase = tick_nxt && (s_nxt.state == psm_pkg::ST_RUN ||
                                        s_nxt.state == psm_pkg::ST_WAIT ||
                                        s_nxt.state == psm_pkg::ST_AHALT);
    s_nxt.mode           = mode_of(s_nxt.state, slow_mode_enable);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= psm_pkg::ST_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign mask_force      = s_r.mask_force;
  assign mask_force_val  = psm_pkg::MASK_ALL_ENABLED;
  assign vector_req      = s_r.vector_req;
  assign vector_is_reset = s_r.vector_is_reset;
  assign wdg_reset_req   = s_r.wdg_reset_req;
  assign clk_gates       = s_r.gates;
  assign psm_mode        = s_r.mode;

  // helper: core ticks spent in the stabilisation state
  logic [psm_pkg::CNT_W-1:0] stab_ticks_r;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stab_ticks_r <= '0;
    end else if (s_r.state != psm_pkg::ST_STAB) begin
      stab_ticks_r <= '0;
    end else if (tick) begin
      stab_ticks_r <= stab_ticks_r + 13'h0001;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  chk_wait_mask_force: assert property (
    (s_r.state == psm_pkg::ST_RUN && wait_for_irq_instr && !halt_instr && !s_r.guard_on)
      |=> mask_force && mask_force_val == 2'h2)
    else $error("wait entry did not force the mask");

  chk_wait_cpu_off: assert property (
    s_r.state == psm_pkg::ST_WAIT |-> !clk_gates.cpu && clk_gates.osc)
    else $error("cpu clocked during wait");

  chk_slow_wait_mode: assert property (
    (s_r.state == psm_pkg::ST_WAIT && $past(s_r.state) == psm_pkg::ST_WAIT &&
     $past(slow_mode_enable)) |-> psm_mode == psm_pkg::MODE_SLOW_WAIT)
    else $error("slow wait mode not reported");

  chk_halt_select: assert property (
    (s_r.state == psm_pkg::ST_RUN && halt_instr && !irq_pending && !s_r.guard_on &&
     timebase_irq_enable) |=> s_r.state == psm_pkg::ST_AHALT)
    else $error("active-halt not entered");

  chk_wdg_reset: assert property (
    (s_r.state == psm_pkg::ST_RUN && halt_instr && !s_r.guard_on && !timebase_irq_enable &&
     watchdog_enabled && !watchdog_in_stop_option)
      |=> wdg_reset_req && s_r.state == psm_pkg::ST_RUN)
    else $error("watchdog reset not raised on halt");

  chk_ahalt_fast_wake: assert property (
    (s_r.state == psm_pkg::ST_AHALT && timebase_irq && !reset_wake_req)
      |=> vector_req && !vector_is_reset && s_r.state == psm_pkg::ST_RUN)
    else $error("active-halt timebase wake delayed");

  chk_ahalt_gates: assert property (
    s_r.state == psm_pkg::ST_AHALT |-> clk_gates.osc && !clk_gates.cpu && !clk_gates.periph)
    else $error("active-halt gating wrong");

  chk_halt_osc_off: assert property (
    s_r.state == psm_pkg::ST_HALT |-> !clk_gates.osc && !clk_gates.cpu && !clk_gates.periph)
    else $error("oscillator running in halt");

  chk_stab_length: assert property (
    (s_r.state == psm_pkg::ST_STAB && tick && s_r.stab_cnt == 13'h0001)
      |-> stab_ticks_r == dly - 13'h0001 ##1 vector_req && clk_gates.osc)
    else $error("stabilisation delay length wrong");

  chk_stab_periph_off: assert property (
    s_r.state == psm_pkg::ST_STAB |-> clk_gates.osc && !clk_gates.periph && !clk_gates.cpu)
    else $error("peripherals clocked during stabilisation");

  chk_run_full_rate: assert property (
    (s_r.state == psm_pkg::ST_RUN && !$past(slow_mode_enable))
      |-> clk_gates.cpu && clk_gates.periph)
    else $error("run mode not at full clock rate");

  chk_slow_half_rate: assert property (
    (slow_mode_enable && clock_prescale_select == 2'h0 && $stable(slow_mode_enable) &&
     $stable(clock_prescale_select) && clk_gates.periph) |=> !clk_gates.periph)
    else $error("slow divide by two gave back-to-back ticks");

  chk_halt_pending_wake: assert property (
    (s_r.state == psm_pkg::ST_RUN && halt_instr && timebase_irq_enable && irq_pending &&
     !s_r.guard_on) |=> vector_req && mask_force && s_r.state == psm_pkg::ST_RUN)
    else $error("pending interrupt did not wake at halt entry");

  cov_wait_wake: cover property (
    s_r.state == psm_pkg::ST_WAIT ##1 s_r.state == psm_pkg::ST_RUN && vector_req);
  cov_ahalt_wake: cover property (
    s_r.state == psm_pkg::ST_AHALT ##1 vector_req && !vector_is_reset);
  cov_halt_exit: cover property (
    s_r.state == psm_pkg::ST_STAB ##1 s_r.state == psm_pkg::ST_RUN && vector_req);
  cov_wdg: cover property (wdg_reset_req);

endmodule

// [rtl/psm_pkg.sv]
package psm_pkg;

  // stabilisation delay, in cpu clock cycles
  localparam int unsigned STAB_SHORT_CYC = 256;
  localparam int unsigned STAB_LONG_CYC  = 4096;
  localparam int unsigned CNT_W          = 13;
  localparam int unsigned DIV_W          = 4;

  // mask level forced into the condition code register on entry
  localparam logic [1:0] MASK_ALL_ENABLED = 2'h2;

  // reported operating mode
  localparam logic [2:0] MODE_RUN         = 3'h0;
  localparam logic [2:0] MODE_SLOW        = 3'h1;
  localparam logic [2:0] MODE_WAIT        = 3'h2;
  localparam logic [2:0] MODE_SLOW_WAIT   = 3'h3;
  localparam logic [2:0] MODE_ACTIVE_HALT = 3'h4;
  localparam logic [2:0] MODE_HALT        = 3'h5;
  localparam logic [2:0] MODE_STABILISE   = 3'h6;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_WAIT,
    ST_AHALT,
    ST_HALT,
    ST_STAB,
    ST_HREST
  } psm_state_e;

  typedef struct packed {
    logic cpu;
    logic periph;
    logic timebase;
    logic osc;
  } clk_gate_s;

  typedef struct packed {
    psm_state_e             state;
    logic [DIV_W-1:0]       div_cnt;
    logic [CNT_W-1:0]       stab_cnt;
    logic                   stab_reset;
    logic [CNT_W-1:0]       guard_cnt;
    logic                   guard_on;
    clk_gate_s              gates;
    logic                   mask_force;
    logic                   vector_req;
    logic                   vector_is_reset;
    logic                   wdg_reset_req;
    logic [2:0]             mode;
  } psm_st_s;

  localparam psm_st_s ST_RESET = '{
    state:           ST_RUN,
    div_cnt:         '0,
    stab_cnt:        '0,
    stab_reset:      1'b0,
    guard_cnt:       '0,
    guard_on:        1'b0,
    gates:           '{cpu: 1'b1, periph: 1'b1, timebase: 1'b1, osc: 1'b1},
    mask_force:      1'b0,
    vector_req:      1'b0,
    vector_is_reset: 1'b0,
    wdg_reset_req:   1'b0,
    mode:            MODE_RUN
  };

endpackage

// [testbench/cpu_model.sv]
module cpu_model #(
  parameter logic [1:0] ISR_LEVEL = 2'h1
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // from the sequencer
  input  wire logic       mask_force,
  input  wire logic [1:0] mask_force_val,
  input  wire logic       vector_req,
  input  wire logic       vector_is_reset,
  // cpu view
  output logic [1:0]      cc_mask,
  output logic [1:0]      stacked_mask
);
  timeunit 1ns;
  timeprecision 1ps;
  // level 3 after reset: maskable interrupts off until software lowers it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cc_mask      <= 2'h3;
      stacked_mask <= 2'h3;
    end else if (vector_req) begin
      stacked_mask <= cc_mask;
      cc_mask      <= vector_is_reset ? 2'h3 : ISR_LEVEL;
    end else if (mask_force) begin
      cc_mask <= mask_force_val;
    end
  end
endmodule

// [testbench/tb_power_saving_mode_control.sv]
module tb_power_saving_mode_control;
  timeunit 1ns;
  timeprecision 1ps;
  // short delays keep the run brief
  localparam int unsigned SHORT_DLY = 4;
  localparam int unsigned LONG_DLY  = 16;
  logic core_clk = 1'b0, resetn = 1'b0, slow_mode_enable = 1'b0;
  logic [1:0] clock_prescale_select = 2'h0;
  logic timebase_irq_enable = 1'b0, long_delay_select = 1'b0;
  logic watchdog_enabled = 1'b0, watchdog_in_stop_option = 1'b1;
  logic wait_for_irq_instr = 1'b0, halt_instr = 1'b0, irq_pending = 1'b0;
  logic irq_wake_capable = 1'b0, timebase_irq = 1'b0, reset_wake_req = 1'b0;
  logic mask_force, vector_req, vector_is_reset, wdg_reset_req;
  logic [1:0] mask_force_val, cc_mask, stacked_mask;
  logic [2:0] psm_mode;
  psm_pkg::clk_gate_s clk_gates;
  int n_fail = 0;
  int samples_checked = 0;
  int cn, pn, tn, vn, n;

  always #5 core_clk = ~core_clk;

  power_saving_mode_control #(.STAB_SHORT(SHORT_DLY), .STAB_LONG(LONG_DLY)) dut_u (
    .core_clk(core_clk), .resetn(resetn), .slow_mode_enable(slow_mode_enable),
    .clock_prescale_select(clock_prescale_select), .timebase_irq_enable(timebase_irq_enable),
    .long_delay_select(long_delay_select), .watchdog_enabled(watchdog_enabled),
    .watchdog_in_stop_option(watchdog_in_stop_option), .wait_for_irq_instr(wait_for_irq_instr),
    .halt_instr(halt_instr), .irq_pending(irq_pending), .irq_wake_capable(irq_wake_capable),
    .timebase_irq(timebase_irq), .reset_wake_req(reset_wake_req), .mask_force(mask_force),
    .mask_force_val(mask_force_val), .vector_req(vector_req),
    .vector_is_reset(vector_is_reset), .wdg_reset_req(wdg_reset_req),
    .clk_gates(clk_gates), .psm_mode(psm_mode));

  cpu_model cpu_u (
    .core_clk(core_clk), .resetn(resetn), .mask_force(mask_force),
    .mask_force_val(mask_force_val), .vector_req(vector_req),
    .vector_is_reset(vector_is_reset), .cc_mask(cc_mask), .stacked_mask(stacked_mask));

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, exp, input string s);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, s, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask

  // one-cycle instruction pulse; answer pulses are visible on return
  // halt is only ever raised on purpose, never from stray data
  task automatic instr(input logic w, input logic h);
    wait_for_irq_instr = w;
    halt_instr = h;
    cyc(1);
    wait_for_irq_instr = 1'b0;
    halt_instr = 1'b0;
  endtask

  task automatic wait_vec(input int lim);
    n = 0;
    while (vector_req !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
    cmp(8'(vector_req), 8'h01, "vector taken");
  endtask

  task automatic count32;
    cn = 0; pn = 0; tn = 0; vn = 0;
    repeat (32) begin
      cyc(1);
      cn += int'(clk_gates.cpu === 1'b1);
      pn += int'(clk_gates.periph === 1'b1);
      tn += int'(clk_gates.timebase === 1'b1);
      vn += int'(vector_req !== 1'b0);
    end
  endtask

  initial begin
    cyc(10);
    resetn = 1'b1;
    count32;
    cmp(8'(psm_mode), 8'(psm_pkg::MODE_RUN), "mode after reset");
    cmp(8'(cn + pn), 8'h40, "run ticks");
    slow_mode_enable = 1'b1;
    for (int p = 0; p < 4; p++) begin
      clock_prescale_select = 2'(p);
      cyc(20);
      count32;
      cmp(8'(pn), 8'(32 >> (p + 1)), "slow ticks");
      cmp(8'(psm_mode), 8'(psm_pkg::MODE_SLOW), "slow mode");
    end
    clock_prescale_select = 2'h0;
    cyc(4);
    instr(1'b1, 1'b0);
    cmp(8'({mask_force, mask_force_val}), 8'h06, "mask force");
    count32;
    cmp(8'(psm_mode), 8'(psm_pkg::MODE_SLOW_WAIT), "slow wait");
    cmp(8'(cn), 8'h00, "cpu stopped");
    cmp(8'(pn), 8'h10, "periph slow");
    cmp(8'(cc_mask), 8'h02, "cc in wait");
    irq_pending = 1'b1;
    wait_vec(4);
    irq_pending = 1'b0;
    cmp(8'(vector_is_reset), 8'h00, "irq vector");
    cyc(2);
    cmp(8'(stacked_mask), 8'h02, "cc stacked");
    cmp(8'(psm_mode), 8'(psm_pkg::MODE_SLOW), "back to slow");
    slow_mode_enable = 1'b0;
    cyc(4);
    instr(1'b1, 1'b0);
    cmp(8'(psm_mode), 8'(psm_pkg::MODE_WAIT), "plain wait");
    reset_wake_req = 1'b1;
    wait_vec(4);
    reset_wake_req = 1'b0;
    cmp(8'(vector_is_reset), 8'h01, "reset vector");
    timebase_irq_enable = 1'b1;
    watchdog_enabled = 1'b1;
    watchdog_in_stop_option = 1'b0;
    cyc(2);
    instr(1'b0, 1'b1);
    cmp(8'(wdg_reset_req), 8'h00, "no watchdog reset");
    cyc(1);
    irq_pending = 1'b1;
    count32;
    irq_pending = 1'b0;
    cmp(8'(psm_mode), 8'(psm_pkg::MODE_ACTIVE_HALT), "active halt");
    cmp(8'(vn), 8'h00, "other irq ignored");
    cmp(8'({clk_gates.osc, 1'b0, cn[0], pn[0]}), 8'h08, "osc on");
    cmp(8'(cn + pn), 8'h00, "cpu periph off");
    cmp(8'(tn), 8'h20, "timebase runs");
    cmp(8'(cc_mask), 8'h02, "cc in active halt");
    timebase_irq = 1'b1;
    wait_vec(2);
    timebase_irq = 1'b0;
    cmp(8'(n), 8'h01, "no delay");
    // enable kept set through the guard period
    cyc(2 * LONG_DLY);
    instr(1'b0, 1'b1);
    reset_wake_req = 1'b1;
    cyc(1);
    reset_wake_req = 1'b0;
    cmp(8'(psm_mode), 8'(psm_pkg::MODE_STABILISE), "stabilise");
    wait_vec(3 * SHORT_DLY);
    cmp(8'(n), 8'(SHORT_DLY), "short dly");
    cmp(8'(vector_is_reset), 8'h01, "reset vector");
    timebase_irq_enable = 1'b0;
    long_delay_select = 1'b1;
    watchdog_in_stop_option = 1'b1;
    cyc(2);
    // irq_pending and timebase_irq are raised only after halt is entered; irq_wake_capable wakes it
    instr(1'b0, 1'b1);
    cmp(8'(mask_force), 8'h01, "halt mask force");
    cyc(1);
    irq_pending = 1'b1;
    timebase_irq = 1'b1;
    count32;
    cmp(8'(psm_mode), 8'(psm_pkg::MODE_HALT), "halt");
    cmp(8'(cn + pn + tn + vn), 8'h00, "all stopped");
    cmp(8'(clk_gates.osc), 8'h00, "osc off");
    irq_pending = 1'b0;
    timebase_irq = 1'b0;
    irq_wake_capable = 1'b1;
    cyc(1);
    irq_wake_capable = 1'b0;
    cmp(8'({clk_gates.osc, clk_gates.periph}), 8'h02, "osc up");
    cmp(8'(psm_mode), 8'(psm_pkg::MODE_STABILISE), "halt stab");
    wait_vec(3 * LONG_DLY);
    cmp(8'(n), 8'(LONG_DLY), "long dly");
    cmp(8'(vector_is_reset), 8'h00, "halt irq vector");
    cyc(1);
    cmp(8'(psm_mode), 8'(psm_pkg::MODE_RUN), "resumed");
    watchdog_in_stop_option = 1'b0;
    instr(1'b0, 1'b1);
    cmp(8'(wdg_reset_req), 8'h01, "watchdog reset");
    cmp(8'(psm_mode == psm_pkg::MODE_HALT), 8'h00, "halt refused");
    watchdog_enabled = 1'b0;
    cyc(4);
    irq_pending = 1'b1;
    timebase_irq_enable = 1'b1;
    for (int h = 0; h < 2; h++) begin
      instr(h == 0, h == 1);
      wait_vec(4);
      cyc(2 * LONG_DLY);
    end
    give_verdict;
  end

  // the sequence needs well under 1500 cycles
  initial begin
    #20000;
    n_fail++;
    give_verdict;
  end
endmodule
